// *** inc/lfsc_regs.vh ***
// constants for the linefeed state control block
`ifndef LFSC_REGS_VH
`define LFSC_REGS_VH
// linefeed state codes (4-bit field; codes 0..7 given as 3-bit values)
`define LFSC_ST_OPEN 3'h0
`define LFSC_ST_FWD_ACTIVE 3'h1
`define LFSC_ST_REV_ACTIVE 3'h2
`define LFSC_ST_FWD_OHT 3'h3
`define LFSC_ST_REV_OHT 3'h4
`define LFSC_ST_TIP_OPEN 3'h5
`define LFSC_ST_RING_OPEN 3'h6
`define LFSC_ST_RINGING 3'h7
`define LFSC_ST_DIAG 4'h8
// state request field is 4 bits; codes 9..F are illegal
`define LFSC_REQ_W 4
// thermal thresholds in degrees C, 9-bit unsigned
`define LFSC_TEMP_W 9
`define LFSC_TJ_NORMAL 9'h091
`define LFSC_TJ_RINGING 9'h0C8
// monitor refresh: 2 kHz minimum at 50 MHz clock
`define LFSC_CLK_HZ 50000000
`define LFSC_REFRESH_HZ 2000
// clock rate over refresh rate, kept at the timer's 16-bit width
`define LFSC_REFRESH_CYC 16'h61A8
// timer start value, so the first period after reset is not longer
`define LFSC_REFRESH_PRELOAD 16'h0001
`define LFSC_SAMPLE_W 16
`endif

// *** rtl/lfsc_refresh_timer.v ***
// refresh tick generator for the monitor result registers
`timescale 1ns/1ns
`default_nettype none
`include "lfsc_regs.vh"
module lfsc_refresh_timer #(
	parameter [15:0] PERIOD = `LFSC_REFRESH_CYC
) (
	input wire clk_sys_in,
	input wire reset_in,
	output reg tick_out
);
	reg [15:0] count_reg; // cycles since last tick

	// one-cycle pulse every PERIOD cycles
	always @(posedge clk_sys_in) begin
		if (reset_in) begin
			// preload: with it the first period after reset is one cycle shorter than the rest
			count_reg <= `LFSC_REFRESH_PRELOAD;
			tick_out <= 1'b0;
		end else if (count_reg == PERIOD - 16'h0001) begin
			count_reg <= 16'h0000;
			tick_out <= 1'b1;
		end else begin
			count_reg <= count_reg + 16'h0001;
			tick_out <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// *** rtl/lfsc_monitor_calc.v ***
// derived loop quantities from lead measurements
`timescale 1ns/1ns
`default_nettype none
`include "lfsc_regs.vh"
module lfsc_monitor_calc (
	input wire clk_sys_in,
	input wire reset_in,
	input wire load_in,
	input wire [15:0] v_tip_in,
	input wire [15:0] v_ring_in,
	input wire [15:0] i_tip_in,
	input wire [15:0] i_ring_in,
	output reg [15:0] v_loop_out,
	output reg [15:0] i_loop_out,
	output reg [15:0] i_long_out
);
	wire [16:0] i_sum; // tip plus ring current, one extra bit

	assign i_sum = {i_tip_in[15], i_tip_in} + {i_ring_in[15], i_ring_in};

	// results only change on a refresh tick so they stay coherent
	always @(posedge clk_sys_in) begin
		if (reset_in) begin
			v_loop_out <= 16'h0000;
			i_loop_out <= 16'h0000;
			i_long_out <= 16'h0000;
		end else if (load_in) begin
			v_loop_out <= v_tip_in - v_ring_in;
			// loop current is the plain difference of the lead currents
			i_loop_out <= i_tip_in - i_ring_in;
			// longitudinal current is the mean of the leads
			i_long_out <= i_sum[16:1];
		end
	end
endmodule
`default_nettype wire

// *** rtl/lfsc_linefeed_ctrl.v ***
// linefeed operating state control with protective shutdown
`timescale 1ns/1ns
`default_nettype none
`include "lfsc_regs.vh"
module lfsc_linefeed_ctrl (
	input wire clk_sys_in,
	input wire reset_in,
	// software state request, taken on any rising clock edge with the strobe high;
	// illegal codes, and writes during a fault with auto_open_dis_in clear, are dropped
	input wire state_wr_in,
	input wire [3:0] state_req_in,
	// protection configuration
	// all levels except the clear, which is a pulse
	input wire alarm_mask_in,
	input wire auto_open_dis_in,
	input wire alarm_clr_in,
	input wire ring_dc_offset_en_in,
	// fault sources
	// fault inputs are levels, read on every cycle
	input wire total_power_fault_in,
	input wire foreign_fault_in,
	input wire [8:0] die_temp_in,
	// raw monitor samples
	input wire [15:0] v_tip_in,
	input wire [15:0] v_ring_in,
	input wire [15:0] v_bat_in,
	input wire [15:0] i_tip_in,
	input wire [15:0] i_ring_in,
	// state and status
	output reg [3:0] state_out,
	output reg power_alarm_out,
	output reg [2:0] fault_cause_out,
	output reg thermal_shutdown_out,
	// line drive controls
	// all of these are decoded from one state, never mixed
	output reg tip_drive_en_out,
	output reg ring_drive_en_out,
	output reg polarity_rev_out,
	output reg supervision_en_out,
	output reg audio_en_out,
	output reg on_hook_transmission_out,
	output reg ring_gen_en_out,
	output reg ring_dc_offset_out,
	output reg diag_mode_out,
	output reg low_power_out,
	// monitor results
	// held steady between refresh ticks
	output reg [15:0] mon_v_tip_out,
	output reg [15:0] mon_v_ring_out,
	output reg [15:0] mon_v_bat_out,
	output reg [15:0] mon_i_tip_out,
	output reg [15:0] mon_i_ring_out,
	output wire [15:0] mon_v_loop_out,
	output wire [15:0] mon_i_loop_out,
	output wire [15:0] mon_i_long_out,
	output reg mon_update_out
);
	// state codes as held in state_reg and shown on state_out
	// 0 open: both drivers off, supervision and audio off, low power
	// 1 forward active: both leads fed, tip above ring, audio on
	// 2 reverse active: both leads fed, ring above tip, audio on
	// 3 forward on-hook transmission: as 1, data path kept up on-hook
	// 4 reverse on-hook transmission: as 2, data path kept up on-hook
	// 5 tip open: ring lead fed only, tip left floating
	// 6 ring open: tip lead fed only, ring left floating
	// 7 ringing: ring generator on both leads, optional dc offset
	// 8 line diagnostics: drivers off, diagnostic resources on
	// codes 9 to 15 are refused, so state_reg never holds them
	// the field is one bit wider than eight states need, so that
	// diagnostics has a code of its own next to the seven feed states
	reg [3:0] state_reg; // current linefeed state
	reg [3:0] state_next; // next linefeed state
	reg [8:0] temp_limit; // active thermal threshold
	reg thermal_trip; // die above threshold
	reg fault_any; // any protective trigger
	wire refresh_tick; // monitor sample strobe

	// request decode is shared by the next-state logic; a function keeps
	// the legal range in one place
	// legal request codes are 0..8
	function req_legal;
		input [3:0] code;
		begin
			req_legal = (code <= `LFSC_ST_DIAG);
		end
	endfunction

	// used for the choice of thermal limit
	// true for states that need the ring generator active
	function is_ringing;
		input [3:0] code;
		begin
			is_ringing = (code == {1'b0, `LFSC_ST_RINGING});
		end
	endfunction

	// thermal protection: the limit follows the state that is in force now,
	// so leaving ringing on a trip drops the limit back to the normal value;
	// a die already hotter than that stays tripped until it cools down.
	// the compare is strict, so a die exactly at the limit keeps running
	// temperature is unsigned degrees, nine bits wide
	// threshold picked by current state
	always @* begin
		temp_limit = `LFSC_TJ_NORMAL;
		if (is_ringing(state_reg)) begin
			temp_limit = `LFSC_TJ_RINGING;
		end
		thermal_trip = (die_temp_in > temp_limit);
		// any of three causes triggers intervention
		fault_any = total_power_fault_in | foreign_fault_in | thermal_trip;
	end

	// a write that lands in a cycle with an active fault, with auto_open_dis_in clear, is dropped
	// without any indication; software must rewrite the state once the
	// alarm has been seen and the fault has gone away.
	// auto_open_dis_in exists only for lab use: with it set, a fault still
	// raises the alarm but the line driver is left exposed
	// next state: protection beats software request
	always @* begin
		state_next = state_reg;
		if (fault_any && !auto_open_dis_in) begin
			// forced Open protects the high-voltage line driver
			state_next = {1'b0, `LFSC_ST_OPEN};
		end else if (state_wr_in && req_legal(state_req_in)) begin
			state_next = state_req_in;
		end
	end

	// synchronous reset puts the line in open; nothing else can reach
	// state_reg except an accepted write or a forced open
	// state register
	always @(posedge clk_sys_in) begin
		if (reset_in) begin
			state_reg <= {1'b0, `LFSC_ST_OPEN};
		end else begin
			state_reg <= state_next;
		end
	end

	// fault_cause_out keeps every cause seen since the last clear, one bit
	// each for total power, foreign voltage or current, and thermal.
	// a clear in the same cycle as a fault loses, so no event is missed;
	// the mask only hides power_alarm_out, the cause bits latch regardless
	// and the alarm comes back one cycle after the mask is lifted
	// alarm latch: set wins over clear, mask only gates output
	always @(posedge clk_sys_in) begin
		if (reset_in) begin
			power_alarm_out <= 1'b0;
			fault_cause_out <= 3'h0;
			thermal_shutdown_out <= 1'b0;
		end else begin
			thermal_shutdown_out <= thermal_trip;
			if (fault_any) begin
				power_alarm_out <= ~alarm_mask_in;
				fault_cause_out <= fault_cause_out |
					{thermal_trip, foreign_fault_in, total_power_fault_in};
			end else if (alarm_clr_in) begin
				power_alarm_out <= 1'b0;
				fault_cause_out <= 3'h0;
			end else if (alarm_mask_in) begin
				// masking hides a pending alarm but the cause stays
				power_alarm_out <= 1'b0;
			end else if (fault_cause_out != 3'h0) begin
				power_alarm_out <= 1'b1;
			end
		end
	end

	// every control output is registered from state_next, the same value
	// that state_reg takes, so the drive lines and state_out change on the
	// same edge and never show a mix of two states.
	// cost: a wide decode sits in front of these flops in the fault path
	// line drive decode from the next state so outputs track state_out
	always @(posedge clk_sys_in) begin
		if (reset_in) begin
			state_out <= {1'b0, `LFSC_ST_OPEN};
			tip_drive_en_out <= 1'b0;
			ring_drive_en_out <= 1'b0;
			polarity_rev_out <= 1'b0;
			supervision_en_out <= 1'b0;
			audio_en_out <= 1'b0;
			on_hook_transmission_out <= 1'b0;
			ring_gen_en_out <= 1'b0;
			ring_dc_offset_out <= 1'b0;
			diag_mode_out <= 1'b0;
			low_power_out <= 1'b1;
		end else begin
			state_out <= state_next;
			// defaults are the Open state: everything off
			tip_drive_en_out <= 1'b0;
			ring_drive_en_out <= 1'b0;
			polarity_rev_out <= 1'b0;
			supervision_en_out <= 1'b0;
			audio_en_out <= 1'b0;
			on_hook_transmission_out <= 1'b0;
			ring_gen_en_out <= 1'b0;
			ring_dc_offset_out <= 1'b0;
			diag_mode_out <= 1'b0;
			low_power_out <= 1'b1;
			case (state_next)
				{1'b0, `LFSC_ST_FWD_ACTIVE}: begin
					// forward polarity: tip more positive than ring
					tip_drive_en_out <= 1'b1;
					ring_drive_en_out <= 1'b1;
					supervision_en_out <= 1'b1;
					audio_en_out <= 1'b1;
					low_power_out <= 1'b0;
				end
				{1'b0, `LFSC_ST_REV_ACTIVE}: begin
					// reverse polarity: ring more positive than tip
					tip_drive_en_out <= 1'b1;
					ring_drive_en_out <= 1'b1;
					polarity_rev_out <= 1'b1;
					supervision_en_out <= 1'b1;
					audio_en_out <= 1'b1;
					low_power_out <= 1'b0;
				end
				{1'b0, `LFSC_ST_FWD_OHT}: begin
					// on-hook transmission keeps the feed up for data
					tip_drive_en_out <= 1'b1;
					ring_drive_en_out <= 1'b1;
					supervision_en_out <= 1'b1;
					audio_en_out <= 1'b1;
					on_hook_transmission_out <= 1'b1;
					low_power_out <= 1'b0;
				end
				{1'b0, `LFSC_ST_REV_OHT}: begin
					// same as forward, with polarity swapped
					tip_drive_en_out <= 1'b1;
					ring_drive_en_out <= 1'b1;
					polarity_rev_out <= 1'b1;
					supervision_en_out <= 1'b1;
					audio_en_out <= 1'b1;
					on_hook_transmission_out <= 1'b1;
					low_power_out <= 1'b0;
				end
				{1'b0, `LFSC_ST_TIP_OPEN}: begin
					// tip left floating, ground start in forward polarity
					ring_drive_en_out <= 1'b1;
					supervision_en_out <= 1'b1;
					low_power_out <= 1'b0;
				end
				{1'b0, `LFSC_ST_RING_OPEN}: begin
					// ring left floating, ground start in reverse polarity
					tip_drive_en_out <= 1'b1;
					polarity_rev_out <= 1'b1;
					supervision_en_out <= 1'b1;
					low_power_out <= 1'b0;
				end
				{1'b0, `LFSC_ST_RINGING}: begin
					// offset follows its enable while ringing lasts
					tip_drive_en_out <= 1'b1;
					ring_drive_en_out <= 1'b1;
					supervision_en_out <= 1'b1;
					ring_gen_en_out <= 1'b1;
					ring_dc_offset_out <= ring_dc_offset_en_in;
					low_power_out <= 1'b0;
				end
				`LFSC_ST_DIAG: begin
					// drivers stay off; diagnostics steer the line themselves
					diag_mode_out <= 1'b1;
					low_power_out <= 1'b0;
				end
				default: begin
					// Open: keep the all-off defaults
					low_power_out <= 1'b1;
				end
			endcase
		end
	end

	// monitor refresh: one tick per refresh period, which is the slowest
	// refresh allowed; raw samples and derived quantities load on the
	// same tick so a reader never pairs values from two samples.
	// the timer is preloaded so the first refresh after reset is no later
	// than any of the following ones
	// periodic sample strobe
	lfsc_refresh_timer #(
		.PERIOD(`LFSC_REFRESH_CYC)
	) u_timer (
		.clk_sys_in(clk_sys_in),
		.reset_in(reset_in),
		.tick_out(refresh_tick)
	);

	// raw monitor registers sampled on each tick
	always @(posedge clk_sys_in) begin
		if (reset_in) begin
			mon_v_tip_out <= 16'h0000;
			mon_v_ring_out <= 16'h0000;
			mon_v_bat_out <= 16'h0000;
			mon_i_tip_out <= 16'h0000;
			mon_i_ring_out <= 16'h0000;
			mon_update_out <= 1'b0;
		end else begin
			// the update pulse rises on the edge that loads the new values
			mon_update_out <= refresh_tick;
			if (refresh_tick) begin
				mon_v_tip_out <= v_tip_in;
				mon_v_ring_out <= v_ring_in;
				mon_v_bat_out <= v_bat_in;
				mon_i_tip_out <= i_tip_in;
				mon_i_ring_out <= i_ring_in;
			end
		end
	end

	// loop voltage, loop current and longitudinal current come from the
	// live lead inputs, not the registered copies, so that they carry the
	// same sample as the raw monitor registers loaded on this tick,
	// and mon_update_out marks the edge on which all eight change
	// derived loop quantities, loaded with the same samples
	lfsc_monitor_calc u_calc (
		.clk_sys_in(clk_sys_in),
		.reset_in(reset_in),
		.load_in(refresh_tick),
		.v_tip_in(v_tip_in),
		.v_ring_in(v_ring_in),
		.i_tip_in(i_tip_in),
		.i_ring_in(i_ring_in),
		.v_loop_out(mon_v_loop_out),
		.i_loop_out(mon_i_loop_out),
		.i_long_out(mon_i_long_out)
	);
endmodule
`default_nettype wire

// *** test/lfsc_loop_model.sv ***
// behavioural subscriber loop seen from the line drivers
`timescale 1ns/1ns
`default_nettype none
module lfsc_loop_model (
	input wire logic clk_in,
	input wire logic off_hook_in,
	input wire logic tip_en_in,
	input wire logic ring_en_in,
	input wire logic rev_in,
	output logic [15:0] v_tip_out,
	output logic [15:0] v_ring_out,
	output logic [15:0] v_bat_out,
	output logic [15:0] i_tip_out,
	output logic [15:0] i_ring_out
);
	logic [15:0] float_reg = 16'h5A5A; // value of an unfed lead
	// an unfed lead floats, so it never holds a stale level
	always @(posedge clk_in) begin
		float_reg <= ~float_reg + 16'h0013;
	end
	// forward: tip near ground, ring near battery; reverse swaps
	assign v_tip_out = !tip_en_in ? float_reg : (rev_in ? 16'hFFD0 : 16'hFFFC);
	assign v_ring_out = !ring_en_in ? ~float_reg : (rev_in ? 16'hFFFC : 16'hFFD0);
	assign v_bat_out = 16'hFFB0;
	// current flows only with both leads fed and the handset lifted
	assign i_tip_out = (tip_en_in && ring_en_in && off_hook_in) ? 16'h0019 : 16'h0000;
	assign i_ring_out = 16'h0000 - i_tip_out;
endmodule
`default_nettype wire

// *** test/lfsc_linefeed_ctrl_chk.sv ***
// port assertions for the linefeed state control block
`timescale 1ns/1ns
`default_nettype none
module lfsc_chk (
	input wire logic clk_sys_in,
	input wire logic reset_in,
	input wire logic state_wr_in,
	input wire logic [3:0] state_req_in,
	input wire logic alarm_mask_in,
	input wire logic auto_open_dis_in,
	input wire logic total_power_fault_in,
	input wire logic foreign_fault_in,
	input wire logic [8:0] die_temp_in,
	input wire logic [3:0] state_out,
	input wire logic power_alarm_out,
	input wire logic thermal_shutdown_out,
	input wire logic tip_drive_en_out,
	input wire logic ring_drive_en_out,
	input wire logic polarity_rev_out,
	input wire logic audio_en_out,
	input wire logic low_power_out,
	input wire logic [15:0] mon_v_tip_out,
	input wire logic [15:0] mon_v_ring_out,
	input wire logic [15:0] mon_v_loop_out,
	input wire logic mon_update_out
);
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (reset_in);
	// no fault of any kind in this cycle
	wire quiet = !total_power_fault_in && !foreign_fault_in && !thermal_shutdown_out && die_temp_in <= 9'h091;
	wire ext_fault = total_power_fault_in || foreign_fault_in; // external fault sources
	wire over_lim = die_temp_in > ((state_out == 4'h7) ? 9'h0C8 : 9'h091); // limit follows state
	logic [15:0] gap_reg; // cycles since last monitor refresh
	// gap counter restarts on each refresh
	always_ff @(posedge clk_sys_in) begin
		gap_reg <= (reset_in || mon_update_out) ? 16'h0000 : gap_reg + 16'h0001;
	end
	sequence s_take;
		state_wr_in && state_req_in <= 4'h8 && quiet;
	endsequence
	sequence s_bad_code;
		state_wr_in && state_req_in > 4'h8 && quiet;
	endsequence
	AST_RESET_OPEN: assert property (disable iff (1'b0) reset_in |=> state_out == 4'h0 && low_power_out) else $error("reset left line fed");
	AST_TAKE: assert property (s_take |=> state_out == $past(state_req_in)) else $error("legal write not applied");
	AST_BAD_CODE: assert property (s_bad_code |=> $stable(state_out)) else $error("illegal code changed state");
	AST_FAULT_OPEN: assert property (ext_fault && !auto_open_dis_in |=> state_out == 4'h0) else $error("fault kept line fed");
	AST_ALARM: assert property (ext_fault && !alarm_mask_in |=> power_alarm_out) else $error("no alarm on fault");
	AST_MASK: assert property (alarm_mask_in |=> !power_alarm_out) else $error("masked alarm shown");
	AST_THERM: assert property (!$past(reset_in) |-> thermal_shutdown_out == $past(over_lim)) else $error("thermal limit wrong");
	AST_THERM_OFF: assert property (thermal_shutdown_out && !auto_open_dis_in |-> ##[0:1] state_out == 4'h0 && low_power_out) else $error("no shutdown");
	AST_OPEN_HIZ: assert property (state_out == 4'h0 |-> !tip_drive_en_out && !ring_drive_en_out && !audio_en_out) else $error("open not quiet");
	AST_ACTIVE: assert property (state_out inside {4'h1, 4'h2} |-> tip_drive_en_out && ring_drive_en_out && audio_en_out && polarity_rev_out == state_out[1]) else $error("active decode");
	AST_LEAD_OPEN: assert property (state_out inside {4'h5, 4'h6} |-> tip_drive_en_out == state_out[1] && ring_drive_en_out == state_out[0]) else $error("lead open decode");
	AST_LOOP_V: assert property (mon_update_out |-> mon_v_loop_out == mon_v_tip_out - mon_v_ring_out) else $error("loop voltage wrong");
	AST_REFRESH: assert property (gap_reg <= 16'h61A8) else $error("monitor refresh too slow");
endmodule
bind lfsc_linefeed_ctrl lfsc_chk u_chk (.clk_sys_in, .reset_in, .state_wr_in, .state_req_in, .alarm_mask_in,
	.auto_open_dis_in, .total_power_fault_in, .foreign_fault_in, .die_temp_in, .state_out, .power_alarm_out,
	.thermal_shutdown_out, .tip_drive_en_out, .ring_drive_en_out, .polarity_rev_out, .audio_en_out, .low_power_out,
	.mon_v_tip_out, .mon_v_ring_out, .mon_v_loop_out, .mon_update_out);
`default_nettype wire

// *** test/test_linefeed_state_control.sv ***
// self-checking bench for the linefeed state control block
`timescale 1ns/1ns
`default_nettype none
module test_linefeed_state_control;
	logic clk_sys_in = 1'b0, reset_in = 1'b1, state_wr_in = 1'b0, alarm_mask_in = 1'b0, auto_open_dis_in = 1'b0;
	logic alarm_clr_in = 1'b0, ring_dc_offset_en_in = 1'b0, total_power_fault_in = 1'b0, foreign_fault_in = 1'b0;
	logic off_hook = 1'b1; // handset state seen by the loop model
	logic [3:0] state_req_in = 4'h0, state_out, cur, code;
	logic [8:0] die_temp_in = 9'h019; // room temperature
	logic [15:0] v_tip, v_ring, v_bat, i_tip, i_ring, m_tip, m_loop;
	logic [15:0] m_ring, m_bat, m_itip, m_iring, m_iloop, m_ilong; // remaining monitor results
	logic sup, on_hook_transmission; // supervision and on-hook transmission enables
	logic [2:0] fault_cause_out;
	logic power_alarm_out, tip_en, ring_en, pol_rev, audio_en, ring_gen, dc_off, diag, low_pwr, mon_upd;
	int mismatches = 0, comparisons = 0, n, gap;
	lfsc_linefeed_ctrl u_dut (.clk_sys_in, .reset_in, .state_wr_in, .state_req_in, .alarm_mask_in, .auto_open_dis_in,
		.alarm_clr_in, .ring_dc_offset_en_in, .total_power_fault_in, .foreign_fault_in, .die_temp_in, .v_tip_in(v_tip),
		.v_ring_in(v_ring), .v_bat_in(v_bat), .i_tip_in(i_tip), .i_ring_in(i_ring), .state_out, .power_alarm_out,
		.fault_cause_out, .thermal_shutdown_out(), .tip_drive_en_out(tip_en), .ring_drive_en_out(ring_en),
		.polarity_rev_out(pol_rev), .supervision_en_out(sup), .audio_en_out(audio_en), .on_hook_transmission_out(on_hook_transmission),
		.ring_gen_en_out(ring_gen), .ring_dc_offset_out(dc_off), .diag_mode_out(diag), .low_power_out(low_pwr),
		.mon_v_tip_out(m_tip), .mon_v_ring_out(m_ring), .mon_v_bat_out(m_bat), .mon_i_tip_out(m_itip),
		.mon_i_ring_out(m_iring), .mon_v_loop_out(m_loop), .mon_i_loop_out(m_iloop), .mon_i_long_out(m_ilong),
		.mon_update_out(mon_upd));
	lfsc_loop_model u_loop (.clk_in(clk_sys_in), .off_hook_in(off_hook), .tip_en_in(tip_en), .ring_en_in(ring_en),
		.rev_in(pol_rev), .v_tip_out(v_tip), .v_ring_out(v_ring), .v_bat_out(v_bat), .i_tip_out(i_tip),
		.i_ring_out(i_ring));
	// 50 MHz system clock
	initial begin
		forever #10 clk_sys_in = ~clk_sys_in;
	end
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic results();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// write strobe stays up so successive calls are back to back
	task automatic wr(input logic [3:0] c);
		state_wr_in = 1'b1;
		state_req_in = c;
		@(negedge clk_sys_in);
	endtask
	// lead feed expected per state code, {tip, ring}
	function automatic logic [1:0] leads(input logic [3:0] c);
		return (c inside {[4'h1:4'h4]}) ? 2'b11 : (c == 4'h5) ? 2'b01 : (c == 4'h6) ? 2'b10 : 2'b00;
	endfunction
	// longitudinal current expected as the signed mean of the lead currents
	function automatic logic [15:0] mean(input logic [15:0] a, input logic [15:0] b);
		logic [16:0] s;
		s = {a[15], a} + {b[15], b};
		return s[16:1];
	endfunction
	task automatic check_state(input logic [3:0] c);
		check(state_out, c);
		if (c <= 4'h6) check({tip_en, ring_en}, leads(c));
		check(audio_en, c inside {[4'h1:4'h4]});
		if (c inside {[4'h1:4'h4]}) check(pol_rev, c == 4'h2 || c == 4'h4);
		check({ring_gen, dc_off}, {c == 4'h7, c == 4'h7 && ring_dc_offset_en_in});
		check(diag, c == 4'h8);
		check({sup, on_hook_transmission}, {c inside {[4'h1:4'h7]}, c inside {4'h3, 4'h4}});
		check(low_pwr, c == 4'h0);
	endtask
	// put the line in a state, apply a fault, then recover and clear
	task automatic trip(input logic [3:0] st, input logic [8:0] t, input logic pw, input logic fv, input logic [2:0] cs);
		wr(st);
		state_wr_in = 1'b0;
		{die_temp_in, total_power_fault_in, foreign_fault_in} = {t, pw, fv};
		repeat (3) @(negedge clk_sys_in);
		check(state_out, (cs != 3'h0 && !auto_open_dis_in) ? 4'h0 : st);
		check(power_alarm_out, cs != 3'h0 && !alarm_mask_in);
		check(fault_cause_out, cs);
		if (cs[2]) check(low_pwr, 1'b1);
		alarm_mask_in = 1'b0;
		{die_temp_in, total_power_fault_in, foreign_fault_in} = {9'h019, 2'b00};
		@(negedge clk_sys_in);
		check(power_alarm_out, cs != 3'h0);
		alarm_clr_in = 1'b1;
		@(negedge clk_sys_in);
		alarm_clr_in = 1'b0;
		@(negedge clk_sys_in);
		check({power_alarm_out, fault_cause_out}, 4'h0);
		auto_open_dis_in = 1'b0;
	endtask
	// bounded wait for the next monitor refresh pulse
	task automatic wait_upd();
		for (gap = 0; gap < 25100 && mon_upd !== 1'b1; gap++) @(negedge clk_sys_in);
		if (gap >= 25100) begin
			mismatches++;
			results();
		end
	endtask
	initial begin
		void'($urandom(32'h0921));
		repeat (5) @(negedge clk_sys_in);
		reset_in = 1'b0;
		check({state_out, low_pwr, tip_en, ring_en}, 7'h04);
		cur = 4'h0;
		// every code in turn, then random codes including illegal ones
		for (n = 0; n < 60; n++) begin
			code = (n < 16) ? n[3:0] : 4'($urandom % 16);
			ring_dc_offset_en_in = 1'($urandom % 2);
			off_hook = 1'($urandom % 2);
			wr(code);
			if (code <= 4'h8) cur = code;
			check_state(cur);
		end
		trip(4'h1, 9'h091, 1'b0, 1'b0, 3'h0);
		trip(4'h1, 9'h092, 1'b0, 1'b0, 3'h4);
		trip(4'h7, 9'h0C8, 1'b0, 1'b0, 3'h0);
		trip(4'h7, 9'h0C9, 1'b0, 1'b0, 3'h4);
		trip(4'h3, 9'h019, 1'b1, 1'b0, 3'h1);
		alarm_mask_in = 1'b1;
		trip(4'h2, 9'h019, 1'b0, 1'b1, 3'h2);
		@(negedge clk_sys_in);
		auto_open_dis_in = 1'b1;
		trip(4'h5, 9'h019, 1'b1, 1'b0, 3'h1);
		off_hook = 1'b1;
		wr(4'h1);
		state_wr_in = 1'b0;
		wait_upd();
		check(m_tip, v_tip);
		check(m_loop, v_tip - v_ring);
		check(m_ring, v_ring);
		check(m_bat, v_bat);
		check(m_itip, i_tip);
		check(m_iring, i_ring);
		check(m_iloop, i_tip - i_ring);
		check(m_ilong, mean(i_tip, i_ring));
		@(negedge clk_sys_in);
		wait_upd();
		check(gap < 25000, 1'b1);
		results();
	end
endmodule
`default_nettype wire
